// [pkg/usbuc_pkg.sv]
// Package: constants and types for the serial-side control block
package usbuc_pkg;
    localparam int          CLK_HZ            = 100_000_000;
    localparam int          REF_HZ            = 48_000_000;
    localparam int          OVERSAMPLE        = 16;
    // Prescaler limits
    localparam logic [13:0] DIV_MIN           = 14'h0002;
    localparam int          DIV_MAX           = 16384;
    localparam logic [13:0] DIV_3M            = 14'h0000;
    localparam logic [13:0] DIV_2M            = 14'h0001;
    // Fixed divisor (in 1/8 units of the 3 MHz base) for the two special values
    localparam logic [16:0] DIV8_3M           = 17'h00008;
    localparam logic [16:0] DIV8_2M           = 17'h0000C;
    // Flush timeout
    localparam int          MS_NS             = 1_000_000;
    localparam int          CLK_NS            = 10;
    localparam int          MS_CYCLES         = MS_NS / CLK_NS;
    localparam logic [7:0]  TMO_MIN           = 8'h01;
    localparam logic [7:0]  TMO_RESET         = 8'h10;
    // Register map
    localparam logic [3:0]  REG_DIVISOR       = 4'h0;
    localparam logic [3:0]  REG_CONFIG        = 4'h1;
    localparam logic [3:0]  REG_TIMEOUT       = 4'h2;
    localparam logic [3:0]  REG_BITBANG       = 4'h3;
    localparam logic [3:0]  REG_STATUS        = 4'h4;
    // Field positions
    localparam int          DIV_FRAC_LSB      = 14;
    localparam int          CFG_ISO_BIT       = 0;
    localparam int          CFG_PULLDN_BIT    = 1;
    localparam int          CFG_BITBANG_BIT   = 2;
    localparam int          CFG_BBDIR_LSB     = 8;
    // Reset values
    localparam logic [16:0] DIVISOR_RESET     = 17'h00138;
    localparam logic [15:0] CONFIG_RESET      = 16'h0000;
    localparam logic [7:0]  BBDIR_RESET       = 8'h00;

    typedef enum logic [1:0] {
        USBUC_BB_IDLE = 2'b00,
        USBUC_BB_WAIT = 2'b01
    } usbuc_bb_state_t;
endpackage

// [pkg/usbuc_tick_if.sv]
// Interface: baud tick between the main block and the prescaler
`timescale 1ns/1ns
interface usbuc_tick_if;
    logic [16:0] divisor;
    logic        tick16;
    logic        restart;
    modport gen  (input divisor, input restart, output tick16);
    modport user (output divisor, output restart, input tick16);
endinterface

// [rtl/usbuc_baud_gen.sv]
// Fractional baud prescaler producing a x16 tick
`timescale 1ns/1ns
module usbuc_baud_gen
    import usbuc_pkg::*;
(
    // Clock and reset
    input  wire logic clock,
    input  wire logic rst_b,
    // Tick link
    usbuc_tick_if.gen tk
);
    import usbuc_pkg::*;

    // Phase accumulator in units of the 48 MHz reference, scaled by 8 on the divisor
    // side; step per system clock is REF_HZ*8/CLK_HZ expressed as a ratio.
    logic [31:0] acc;
    logic [31:0] next_acc;
    logic        tick16;
    wire  [31:0] ref_step  = 32'(REF_HZ / 1000);
    // Scale folded into one factor so the largest divisor still fits 32 bits
    wire  [31:0] limit     = 32'(tk.divisor) * 32'(CLK_HZ / 8000);
    wire         wrap      = (acc + ref_step) >= limit;

    assign next_acc = tk.restart ? 32'h0 : (wrap ? acc + ref_step - limit : acc + ref_step);

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            acc    <= 32'h0;
            tick16 <= 1'b0;
        end
        else
        begin
            acc    <= next_acc;
            tick16 <= wrap && !tk.restart;
        end
    end

    assign tk.tick16 = tick16;
endmodule // usbuc_baud_gen

// [rtl/usbuc_ctrl.sv]
// Serial-side control: prescaler, flush timer, bit-bang, power gating
`timescale 1ns/1ns
module usbuc_ctrl
    import usbuc_pkg::*;
(
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst_b,
    // Register port
    input  wire logic [3:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic      [31:0] reg_rdata,
    // Transmit byte stream from the host side
    input  wire logic [7:0]  tx_byte,
    input  wire logic        tx_valid,
    output logic             tx_ready,
    // Serial-mode lines to and from the UART core
    input  wire logic [7:0]  uart_out,
    input  wire logic [7:0]  uart_oe,
    input  wire logic        uart_tx_busy,
    input  wire logic        uart_break,
    input  wire logic        rx_byte_stored,
    input  wire logic        rx_buffer_empty,
    output logic             rx_flush,
    output logic             baud_tick16,
    // Interface pins
    input  wire logic [7:0]  pin_in,
    output logic      [7:0]  pin_out,
    output logic      [7:0]  pin_oe,
    output logic      [7:0]  pin_pulldown,
    output logic             rs485_driver_enable,
    // Power and USB state
    input  wire logic        enumerated_flag,
    input  wire logic        suspend_n,
    input  wire logic        usb_reset_n,
    output logic             power_switch_enable_n,
    output logic             iso_mode
);
    import usbuc_pkg::*;

    usbuc_tick_if tk ();

    logic [16:0]     divisor;
    logic [15:0]     config_reg;
    logic [7:0]      timeout_ms;
    logic [7:0]      bb_dir;
    logic [7:0]      bb_latch;
    logic [7:0]      pin_s1;
    logic [7:0]      pin_s2;
    logic [2:0]      ctl_s1;
    logic [2:0]      ctl_s2;
    logic [3:0]      sub16;
    logic [23:0]     ms_cnt;
    logic [7:0]      ms_left;
    logic            flush_armed;
    usbuc_bb_state_t bb_state;
    usbuc_bb_state_t next_bb_state;

    // Decode
    wire        wr_div   = reg_write && reg_addr == REG_DIVISOR;
    wire        wr_cfg   = reg_write && reg_addr == REG_CONFIG;
    wire        wr_tmo   = reg_write && reg_addr == REG_TIMEOUT;
    wire        bb_on    = config_reg[CFG_BITBANG_BIT];
    wire [13:0] div_int  = divisor[13:0];
    wire [2:0]  div_frac = divisor[DIV_FRAC_LSB +: 3];

    // Effective divisor in eighths of the 3 MHz base period
    wire        div_special = div_int == DIV_3M || div_int == DIV_2M;
    wire [16:0] div8 = !div_special        ? {div_int, 3'b000} + {14'h0000, div_frac} :
                       (div_int == DIV_3M) ? DIV8_3M : DIV8_2M;

    // Prescaler sets x16 tick from the reference clock
    assign tk.divisor = div8;
    assign tk.restart = wr_div;

    usbuc_baud_gen u_baud (
        .clock (clock),
        .rst_b (rst_b),
        .tk    (tk)
    );

    // Bit-bang pacing: one byte per baud period (16 ticks)
    wire bit_period = tk.tick16 && sub16 == 4'hF;
    wire bb_take    = bb_on && tx_valid && bb_state == USBUC_BB_IDLE;

    always_comb
    begin
        next_bb_state = bb_state;
        case (bb_state)
            USBUC_BB_IDLE: if (bb_take) next_bb_state = USBUC_BB_WAIT;
            USBUC_BB_WAIT: if (bit_period || !bb_on) next_bb_state = USBUC_BB_IDLE;
            default:       next_bb_state = USBUC_BB_IDLE;
        endcase
    end

    // Power gating and pulldown
    wire power_on   = ctl_s2[0] && ctl_s2[1] && ctl_s2[2];
    wire pull_lines = config_reg[CFG_PULLDN_BIT] && !power_on;

    // Flush timer
    wire ms_tick    = ms_cnt == 24'(MS_CYCLES - 1);
    wire tmo_expire = flush_armed && ms_tick && ms_left == TMO_MIN;

    // Pin muxing
    wire [7:0] next_pin_out = bb_on ? bb_latch : uart_out;
    wire [7:0] next_pin_oe  = bb_on ? bb_dir   : uart_oe;
    // Break holds the line low, so the driver must stay on through it
    wire next_de = !bb_on && (uart_tx_busy || uart_break);

    wire [31:0] rd_mux =
        (reg_addr == REG_DIVISOR) ? {15'h0000, divisor} :
        (reg_addr == REG_CONFIG)  ? {16'h0000, config_reg} :
        (reg_addr == REG_TIMEOUT) ? {24'h000000, timeout_ms} :
        (reg_addr == REG_BITBANG) ? {24'h000000, pin_s2} :
        (reg_addr == REG_STATUS)  ? {29'h00000000, flush_armed, bb_on, power_on} :
        32'h00000000;

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            divisor    <= DIVISOR_RESET;
            config_reg <= CONFIG_RESET;
            timeout_ms <= TMO_RESET;
        end
        else
        begin
            // Divisor writes above the max are clipped by width: 17 bits
            if (wr_div) divisor <= reg_wdata[16:0];
            if (wr_cfg) config_reg <= reg_wdata[15:0];
            // Zero is held off: the timer needs at least one millisecond
            if (wr_tmo) timeout_ms <= (reg_wdata[7:0] == 8'h00) ? TMO_MIN : reg_wdata[7:0];
        end
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pin_s1 <= 8'h00;
            pin_s2 <= 8'h00;
            ctl_s1 <= 3'b000;
            ctl_s2 <= 3'b000;
        end
        else
        begin
            pin_s1 <= pin_in;
            pin_s2 <= pin_s1;
            ctl_s1 <= {usb_reset_n, suspend_n, enumerated_flag};
            ctl_s2 <= ctl_s1;
        end
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            bb_state <= USBUC_BB_IDLE;
            bb_latch <= 8'h00;
            bb_dir   <= BBDIR_RESET;
            sub16    <= 4'h0;
        end
        else
        begin
            bb_state <= next_bb_state;
            bb_dir   <= config_reg[CFG_BBDIR_LSB +: 8];
            if (bb_take) bb_latch <= tx_byte;
            if (bb_take) sub16 <= 4'h0;
            else if (tk.tick16) sub16 <= sub16 + 4'h1;
        end
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ms_cnt      <= 24'h000000;
            ms_left     <= TMO_RESET;
            flush_armed <= 1'b0;
            rx_flush    <= 1'b0;
        end
        else
        begin
            rx_flush <= tmo_expire;
            if (rx_byte_stored)
            begin
                // New byte restarts the whole wait
                ms_cnt      <= 24'h000000;
                ms_left     <= timeout_ms;
                flush_armed <= 1'b1;
            end
            else if (flush_armed)
            begin
                ms_cnt <= ms_tick ? 24'h000000 : ms_cnt + 24'h000001;
                if (ms_tick) ms_left <= ms_left - 8'h01;
                if (tmo_expire || rx_buffer_empty) flush_armed <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            reg_rdata             <= 32'h00000000;
            pin_out               <= 8'h00;
            pin_oe                <= 8'h00;
            pin_pulldown          <= 8'h00;
            rs485_driver_enable   <= 1'b0;
            power_switch_enable_n <= 1'b1;
            iso_mode              <= 1'b0;
            tx_ready              <= 1'b0;
            baud_tick16           <= 1'b0;
        end
        else
        begin
            reg_rdata             <= reg_read ? rd_mux : 32'h00000000;
            pin_out               <= next_pin_out;
            pin_oe                <= pull_lines ? 8'h00 : next_pin_oe;
            pin_pulldown          <= {8{pull_lines}};
            rs485_driver_enable   <= next_de;
            power_switch_enable_n <= !power_on;
            iso_mode              <= config_reg[CFG_ISO_BIT];
            tx_ready              <= next_bb_state == USBUC_BB_IDLE && bb_on && !bb_take;
            baud_tick16           <= tk.tick16;
        end
    end
endmodule // usbuc_ctrl

// [test/usbuc_ctrl_sva.sv]
// Checker: port-level timing of the serial-side control block
`timescale 1ns/1ns
module usbuc_ctrl_sva (
    // Clock and reset
    input wire logic       clock,
    input wire logic       rst_b,
    // Watched ports
    input wire logic       reg_write,
    input wire logic       rx_byte_stored,
    input wire logic       rx_flush,
    input wire logic       uart_break,
    input wire logic       uart_tx_busy,
    input wire logic       rs485_driver_enable,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] pin_pulldown,
    input wire logic       enumerated_flag,
    input wire logic       suspend_n,
    input wire logic       usb_reset_n,
    input wire logic       power_switch_enable_n,
    input wire logic       iso_mode
);
    wire up = enumerated_flag && suspend_n && usb_reset_n;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    a_power_on: assert property (up [*3] |=> !power_switch_enable_n)
        else $error("power enable late");
    a_power_off: assert property (!up |-> ##3 power_switch_enable_n)
        else $error("power enable stuck");
    a_pulldn_power: assert property (!power_switch_enable_n && $past(!power_switch_enable_n)
        |-> pin_pulldown == 8'h00) else $error("pull-down while powered");
    a_pulldn_float: assert property (pin_pulldown != 8'h00 |-> pin_oe == 8'h00)
        else $error("driving against pull-down");
    a_flush_pulse: assert property (rx_flush |=> !rx_flush)
        else $error("flush pulse too long");
    a_flush_restart: assert property (rx_byte_stored |-> ##2 !rx_flush [*8])
        else $error("flush right after byte");
    a_driver_idle: assert property (!uart_break && !uart_tx_busy |=> !rs485_driver_enable)
        else $error("driver enable without cause");
    a_iso_hold: assert property (!$past(reg_write) && !$past(reg_write, 2) |-> $stable(iso_mode))
        else $error("iso mode moved");
endmodule // usbuc_ctrl_sva

bind usbuc_ctrl usbuc_ctrl_sva chk (.clock, .rst_b, .reg_write, .rx_byte_stored, .rx_flush, .uart_break,
    .uart_tx_busy, .rs485_driver_enable, .pin_oe, .pin_pulldown, .enumerated_flag, .suspend_n,
    .usb_reset_n, .power_switch_enable_n, .iso_mode);

// [test/usbuc_peer.sv]
// Partner: peripheral sitting on the interface pins
`timescale 1ns/1ns
module usbuc_peer (
    // Clock
    input  wire logic       clock,
    // Pin side of the block
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe,
    input  wire logic [7:0] pin_pulldown,
    // Lines the peripheral drives itself
    input  wire logic [7:0] peer_drive,
    input  wire logic [7:0] peer_oe,
    output logic      [7:0] pin_in
);
    logic [7:0] float_pat = 8'h55;
    // Floating lines toggle so a stale value never reads as valid
    always_ff @(posedge clock)
        float_pat <= ~float_pat;
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & peer_oe & peer_drive)
        | (~pin_oe & ~peer_oe & ~pin_pulldown & float_pat);
endmodule // usbuc_peer

// [test/tb_usbuc_ctrl.sv]
// Testbench: registers, baud, flush, power and bit-bang
`timescale 1ns/1ns
module tb_usbuc_ctrl;
    import usbuc_pkg::*;
    logic        clock = 1'b0, rst_b = 1'b0;
    logic [3:0]  reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0, reg_rdata;
    logic        reg_write = 1'b0, reg_read = 1'b0;
    logic [7:0]  tx_byte = 8'h00, uart_out = 8'h00, uart_oe = 8'h00;
    logic        tx_valid = 1'b0, tx_ready, uart_tx_busy = 1'b0, uart_break = 1'b0;
    logic        rx_byte_stored = 1'b0, rx_buffer_empty = 1'b0, rx_flush, baud_tick16;
    logic [7:0]  pin_in, pin_out, pin_oe, pin_pulldown, peer_drive = 8'h3C, peer_oe = 8'h00;
    logic        rs485_driver_enable, power_switch_enable_n, iso_mode;
    logic        enumerated_flag = 1'b0, suspend_n = 1'b0, usb_reset_n = 1'b0;
    logic [16:0] bdiv [6] = '{17'h00000, 17'h00001, 17'h10001, 17'h10000, 17'h10002, 17'h04003};
    int          bexp [6] = '{480, 320, 320, 480, 192, 154};
    int          error_cnt = 0, n_checks = 0, cnt;

    usbuc_ctrl dut (.clock, .rst_b, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .tx_byte,
        .tx_valid, .tx_ready, .uart_out, .uart_oe, .uart_tx_busy, .uart_break, .rx_byte_stored,
        .rx_buffer_empty, .rx_flush, .baud_tick16, .pin_in, .pin_out, .pin_oe, .pin_pulldown,
        .rs485_driver_enable, .enumerated_flag, .suspend_n, .usb_reset_n, .power_switch_enable_n, .iso_mode);
    usbuc_peer peer (.clock, .pin_out, .pin_oe, .pin_pulldown, .peer_drive, .peer_oe, .pin_in);

    initial
        forever #5 clock = ~clock;

    task automatic conclude();
        if (error_cnt == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask
    // Strobe, then one idle cycle so a strobe is never reassigned in one step
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
        @(posedge clock);
    endtask
    task automatic rc(input logic [3:0] a, input logic [31:0] e, input string n);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        #1 chk(n, reg_rdata, e);
        @(posedge clock);
    endtask
    task automatic bb(input logic [7:0] b);
        int i;
        tx_byte <= b;
        tx_valid <= 1'b1;
        for (i = 0; i < 300 && tx_ready !== 1'b1; i++)
            @(posedge clock);
        chk("bb wait", 32'(i < 300), 32'h1);
        @(posedge clock);
        tx_valid <= 1'b0;
    endtask

    initial
    begin
        // Tests need about 107k cycles, nearly all of it the 1 ms flush wait
        repeat (112000) @(posedge clock);
        error_cnt++;
        conclude();
    end

    initial
    begin
        cyc(2);
        rst_b <= 1'b1;
        cyc(1);
        rc(REG_DIVISOR, 32'h00000138, "div rst");
        rc(REG_TIMEOUT, 32'h00000010, "tmo rst");
        wr(4'hF, 32'hFFFFFFFF);
        rc(4'hF, 32'h0, "unmapped");
        for (int f = 0; f < 8; f++)
        begin
            wr(REG_DIVISOR, {15'h0, f[2:0], 14'h0002});
            rc(REG_DIVISOR, {15'h0, f[2:0], 14'h0002}, "div frac");
        end
        wr(REG_DIVISOR, 32'h00003FFF);
        rc(REG_DIVISOR, 32'h00003FFF, "div max");
        for (int i = 0; i < 6; i++)
        begin
            wr(REG_DIVISOR, {15'h0, bdiv[i]});
            cyc(20);
            cnt = 0;
            repeat (1000) @(posedge clock) cnt += (baud_tick16 === 1'b1);
            chk("baud", 32'(cnt >= bexp[i] - 2 && cnt <= bexp[i] + 2), 32'h1);
        end
        wr(REG_TIMEOUT, 32'h0);
        rc(REG_TIMEOUT, 32'h1, "tmo min");
        wr(REG_TIMEOUT, 32'hFF);
        rc(REG_TIMEOUT, 32'hFF, "tmo max");
        wr(REG_TIMEOUT, 32'h1);
        rx_byte_stored <= 1'b1;
        cyc(1);
        rx_byte_stored <= 1'b0;
        for (cnt = 0; cnt < MS_CYCLES + 100 && rx_flush !== 1'b1; cnt++)
            @(posedge clock);
        chk("flush", 32'(cnt >= MS_CYCLES - 10 && cnt <= MS_CYCLES + 10), 32'h1);
        rx_byte_stored <= 1'b1;
        cyc(1);
        rx_byte_stored <= 1'b0;
        rc(REG_STATUS, 32'h4, "armed");
        rx_buffer_empty <= 1'b1;
        cyc(1);
        rx_buffer_empty <= 1'b0;
        rc(REG_STATUS, 32'h0, "disarmed");
        enumerated_flag <= 1'b1;
        suspend_n <= 1'b1;
        usb_reset_n <= 1'b1;
        wr(REG_CONFIG, 32'h2);
        cyc(4);
        chk("pwr on", power_switch_enable_n, 1'b0);
        chk("pd on", pin_pulldown, 8'h00);
        suspend_n <= 1'b0;
        cyc(5);
        chk("pwr off", power_switch_enable_n, 1'b1);
        chk("pd off", pin_pulldown, 8'hFF);
        rc(REG_BITBANG, 32'h0, "pins low");
        suspend_n <= 1'b1;
        wr(REG_CONFIG, 32'h1);
        cyc(2);
        chk("iso", iso_mode, 1'b1);
        uart_break <= 1'b1;
        cyc(3);
        chk("brk drv", rs485_driver_enable, 1'b1);
        uart_break <= 1'b0;
        wr(REG_DIVISOR, 32'h0);
        wr(REG_CONFIG, 32'h0000FF04);
        cyc(2);
        chk("bb oe", pin_oe, 8'hFF);
        chk("bb rdy", tx_ready, 1'b1);
        bb(8'hA5);
        cyc(3);
        chk("bb byte", pin_out, 8'hA5);
        fork
            bb(8'h5A);
            begin
                cnt = 0;
                repeat (200) @(posedge clock) cnt += (pin_out === 8'hA5 && baud_tick16 === 1'b1);
            end
        join
        chk("bb pace", 32'(cnt >= 13 && cnt <= 18), 32'h1);
        chk("bb next", pin_out, 8'h5A);
        wr(REG_CONFIG, 32'h4);
        peer_oe <= 8'hFF;
        cyc(4);
        rc(REG_BITBANG, 32'h3C, "bb in");
        peer_oe <= 8'h00;
        uart_out <= 8'h81;
        uart_oe <= 8'hC3;
        wr(REG_CONFIG, 32'h0);
        cyc(3);
        chk("ser out", pin_out, 8'h81);
        chk("ser oe", pin_oe, 8'hC3);
        chk("iso off", iso_mode, 1'b0);
        chk("rdy off", tx_ready, 1'b0);
        conclude();
    end
endmodule // tb_usbuc_ctrl
